// File: design/vmr_defines.svh
`ifndef VMR_DEFINES_SVH
`define VMR_DEFINES_SVH
// ==========================================
// Register offsets
`define VMR_OFS_RESULT 6'h11
`define VMR_OFS_CONTROL 6'h12
`define VMR_OFS_RATE 6'h20
// ==========================================
// Reset values
`define VMR_CONTROL_RST 16'h001F
`define VMR_RATE_RST 2'h2
// ==========================================
// Field positions
`define VMR_CTL_ATE_BIT 5
`define VMR_CTL_EN_LSB 6
`define VMR_CTL_EN_MSB 10
`define VMR_CTL_LOWRATE_MSB 4
// ==========================================
// Timing in microseconds, clock in MHz
`define VMR_VOLT_CONV_US 1420
`define VMR_TEMP_CONV_US 7500
`define VMR_INTERVAL_91_US 91000
`define VMR_CLK_MHZ 25
`endif

// File: design/vmr_pkg.sv
package vmr_pkg;
    typedef enum logic [1:0] {VMR_IDLE, VMR_TEMP, VMR_VOLT} vmr_phase_t;
    typedef logic [8:0] vmr_code_t;
endpackage

// File: design/vmr_interval_timer.sv
`include "vmr_defines.svh"
// ==========================================
// Interval ticker: pulse per period in counts of clk
module vmr_interval_timer #(
    parameter int unsigned WIDTH = 28
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic run,
    input wire logic [WIDTH-1:0] period,
    // Tick
    output logic tick
);
    logic [WIDTH-1:0] cnt_q;

    // Count down, reload one short so ticks land exactly period cycles apart
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else if (cnt_q == '0)
        begin
            cnt_q <= period - WIDTH'(1);
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q - WIDTH'(1);
            tick <= 1'b0;
        end
    end
endmodule

// File: design/vmr_voltage_readout.sv
// Functional notes
// - Result stored left-justified, 9 bits in readout bits 15..7.
// - Readout bits 4..2 carry the index of the measured sensor.
// - Reserved readout and control bits always read zero.
// - Index 0..4 maps 2.5V,1.2V,3.3V standby,5V,12V; nominal code 384.
// - Reset returns control register to 1Fh.
// - Control bits 4..0 are read-only; writes ignored.
// - Attention allowed only with control bit 5 and some enable set.
// - Bit 6 enables sensor 0, bits 10..7 sensors 1..4; default off.
// - Rate register holds two-bit select, reset 2h, upper bits zero.
// - Rate table: continuous/91/182/364 ms, low power 91/364/728/1456 ms.
// - Continuous cycle: two remote, one local, five voltage conversions.
// - Interval chosen from rate select plus low-power control bit.
// - With attention enabled, master reads at the conversion rate.
// - Enabled sensors scanned ascending round-robin, disabled skipped.
// - New result sets ready flag; readout read clears ready and overrun.
// - Unread result overwritten, overrun flag set.
// - Out-of-range inputs saturate at all ones or all zeros.
`include "vmr_defines.svh"
module vmr_voltage_readout
    import vmr_pkg::*;
#(
    parameter int unsigned NUM_SENSORS = 5,
    parameter int unsigned VOLT_CONV_CYCLES = `VMR_VOLT_CONV_US * `VMR_CLK_MHZ,
    parameter int unsigned TEMP_CONV_CYCLES = `VMR_TEMP_CONV_US * `VMR_CLK_MHZ,
    parameter int unsigned BASE_INTERVAL_CYCLES = `VMR_INTERVAL_91_US * `VMR_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // Device control low-power bit
    input wire logic lowPowerFlag,
    // Converter result, sampled at end of each voltage conversion
    input wire logic [9:0] adcRaw,
    input wire logic adcUnder,
    // Status and attention
    output logic voltResultReadyFlag,
    output logic voltOverrunFlag,
    output logic attentionReq,
    output logic [2:0] convSensor
);
    localparam int unsigned TW = 28;
    localparam int unsigned CYC_W = 20;

    logic [15:0] ctl_q;
    logic [1:0] rate_q;
    logic [8:0] result_q;
    logic [2:0] index_q;
    logic [2:0] cur_q;
    logic [CYC_W-1:0] conv_q;
    logic [2:0] tempLeft_q;
    vmr_phase_t phase_q;
    logic [TW-1:0] period;
    logic tick;
    logic pending_q;
    logic [NUM_SENSORS-1:0] enables;
    logic anyEnabled;
    logic store;
    logic readResult;
    vmr_code_t satCode;

    assign enables = ctl_q[`VMR_CTL_EN_MSB:`VMR_CTL_EN_LSB];
    assign anyEnabled = |enables;
    assign readResult = regRd && (regAddr == `VMR_OFS_RESULT);

    // Next enabled sensor above the given index, wrapping round
    function automatic logic [2:0] nextSensor(input logic [2:0] from,
                                               input logic [NUM_SENSORS-1:0] en);
        logic [2:0] idx;
        logic [2:0] pick;
        logic found;
        pick = from;
        found = 1'b0;
        for (int k = 1; k <= NUM_SENSORS; k++)
        begin
            idx = 3'((32'(from) + k) % NUM_SENSORS);
            if (!found && en[idx])
            begin
                pick = idx;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // ==========================================
    // Registers written by the master
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl_q <= `VMR_CONTROL_RST;
            rate_q <= `VMR_RATE_RST;
        end
        else if (regWr)
        begin
            if (regAddr == `VMR_OFS_CONTROL)
                ctl_q[`VMR_CTL_EN_MSB:`VMR_CTL_ATE_BIT] <=
                    regWdata[`VMR_CTL_EN_MSB:`VMR_CTL_ATE_BIT];
            if (regAddr == `VMR_OFS_RATE)
                rate_q <= regWdata[1:0];
        end
    end

    // ==========================================
    // Interval from select and low power: multiples of the 91 ms unit
    always_comb
    begin
        unique case ({lowPowerFlag, rate_q})
            3'b000: period = '0;
            3'b001: period = TW'(BASE_INTERVAL_CYCLES);
            3'b010: period = TW'(BASE_INTERVAL_CYCLES * 2);
            3'b011: period = TW'(BASE_INTERVAL_CYCLES * 4);
            3'b100: period = TW'(BASE_INTERVAL_CYCLES);
            3'b101: period = TW'(BASE_INTERVAL_CYCLES * 4);
            3'b110: period = TW'(BASE_INTERVAL_CYCLES * 8);
            3'b111: period = TW'(BASE_INTERVAL_CYCLES * 16);
        endcase
    end

    // Continuous mode never waits, so the timer only runs for timed selects
    vmr_interval_timer #(.WIDTH(TW)) uTimer (
        .clk(clk),
        .rstn(rstn),
        .run(anyEnabled && (period != '0)),
        .period(period),
        .tick(tick)
    );

    // Saturate: the 10-bit raw value can exceed the 9-bit field
    always_comb
    begin
        if (adcUnder)
            satCode = '0;
        else if (adcRaw[9])
            satCode = '1;
        else
            satCode = adcRaw[8:0];
    end

    // ==========================================
    // Scan sequencer: temp slots then voltage slots per cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q <= VMR_IDLE;
            conv_q <= '0;
            tempLeft_q <= '0;
            cur_q <= 3'(NUM_SENSORS - 1);
            pending_q <= 1'b0;
        end
        else if (!anyEnabled)
        begin
            phase_q <= VMR_IDLE;
            pending_q <= 1'b0;
        end
        else
        begin
            if (tick)
                pending_q <= 1'b1;
            unique case (phase_q)
                VMR_IDLE:
                begin
                    if (period == '0 || pending_q || tick)
                    begin
                        pending_q <= 1'b0;
                        phase_q <= VMR_TEMP;
                        tempLeft_q <= 3'd3;
                        conv_q <= CYC_W'(TEMP_CONV_CYCLES - 1);
                        cur_q <= 3'(NUM_SENSORS - 1);
                    end
                end
                VMR_TEMP:
                begin
                    if (conv_q != '0)
                        conv_q <= conv_q - CYC_W'(1);
                    else if (tempLeft_q != 3'd1)
                    begin
                        tempLeft_q <= tempLeft_q - 3'd1;
                        conv_q <= CYC_W'(TEMP_CONV_CYCLES - 1);
                    end
                    else
                    begin
                        phase_q <= VMR_VOLT;
                        cur_q <= nextSensor(cur_q, enables);
                        conv_q <= CYC_W'(VOLT_CONV_CYCLES - 1);
                    end
                end
                VMR_VOLT:
                begin
                    if (conv_q != '0)
                        conv_q <= conv_q - CYC_W'(1);
                    else if (nextSensor(cur_q, enables) > cur_q)
                    begin
                        cur_q <= nextSensor(cur_q, enables);
                        conv_q <= CYC_W'(VOLT_CONV_CYCLES - 1);
                    end
                    else
                        phase_q <= VMR_IDLE;
                end
                default: phase_q <= VMR_IDLE;
            endcase
        end
    end

    assign store = anyEnabled && (phase_q == VMR_VOLT) && (conv_q == '0) && enables[cur_q];

    // ==========================================
    // Result register and status flags; a new result beats a read clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            result_q <= '0;
            index_q <= '0;
            voltResultReadyFlag <= 1'b0;
            voltOverrunFlag <= 1'b0;
        end
        else if (store)
        begin
            result_q <= satCode;
            index_q <= cur_q;
            voltResultReadyFlag <= 1'b1;
            // A read in the same cycle took the old result, so nothing was lost
            if (readResult)
                voltOverrunFlag <= 1'b0;
            else if (voltResultReadyFlag)
                voltOverrunFlag <= 1'b1;
        end
        else if (readResult)
        begin
            voltResultReadyFlag <= 1'b0;
            voltOverrunFlag <= 1'b0;
        end
    end

    // Attention pulse per stored result, gated by ATE
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            attentionReq <= 1'b0;
        else
            attentionReq <= store && ctl_q[`VMR_CTL_ATE_BIT] && anyEnabled;
    end

    // Sensor under conversion, for the analog front end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            convSensor <= '0;
        else
            convSensor <= cur_q;
    end

    // ==========================================
    // Registered read data
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            regRdata <= '0;
        else if (regRd)
        begin
            unique case (regAddr)
                `VMR_OFS_RESULT: regRdata <= {result_q, 2'b00, index_q, 2'b00};
                `VMR_OFS_CONTROL: regRdata <= {5'h00, ctl_q[10:0]};
                `VMR_OFS_RATE: regRdata <= {14'h0000, rate_q};
                default: regRdata <= '0;
            endcase
        end
    end
endmodule

// File: testbench/vmr_adc_model.sv
// ========
// Converter model: sensor 0 under range, sensor 4 over range
module vmr_adc_model (
    // Converter side
    input wire logic [2:0] convSensor,
    output logic [9:0] adcRaw,
    output logic adcUnder
);
    timeunit 1ns;
    timeprecision 1ns;
    // Value follows the sensor being converted, distinct per index
    always_comb
    begin
        adcUnder = (convSensor == 3'h0);
        adcRaw = (convSensor == 3'h4) ? 10'h3FF : 10'h180 + {7'h00, convSensor};
    end
endmodule

// File: testbench/vmr_voltage_readout_asserts.sv
// ========
// Port checker
module vmr_voltage_readout_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access
    input wire logic regRd,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regRdata,
    // Status
    input wire logic voltResultReadyFlag,
    input wire logic voltOverrunFlag,
    input wire logic attentionReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Read-back formats
    ctl_fixed_a: assert property (regRd && regAddr == 6'h12 |=>
        regRdata[15:11] == 5'h00 && regRdata[4:0] == 5'h1F) else $error("ctl fixed bits");
    res_fixed_a: assert property (regRd && regAddr == 6'h11 |=>
        regRdata[6:5] == 2'h0 && regRdata[1:0] == 2'h0) else $error("result zero bits");
    rate_fixed_a: assert property (regRd && regAddr == 6'h20 |=>
        regRdata[15:2] == 14'h0000) else $error("rate zero bits");
    res_index_a: assert property (regRd && regAddr == 6'h11 |=>
        regRdata[4:2] <= 3'h4) else $error("bad index");
    // Flags; a result read always drops overrun
    rd_clear_a: assert property (regRd && regAddr == 6'h11 |=> !voltOverrunFlag)
        else $error("overrun kept");
    overrun_cause_a: assert property ($rose(voltOverrunFlag) |-> $past(voltResultReadyFlag))
        else $error("overrun no cause");
    ready_hold_a: assert property (voltResultReadyFlag && !(regRd && regAddr == 6'h11)
        |=> voltResultReadyFlag) else $error("ready lost");
    attn_pulse_a: assert property (attentionReq |=> !attentionReq)
        else $error("attention long");
    attn_ready_a: assert property (attentionReq |-> voltResultReadyFlag)
        else $error("attention no result");
    res_read_c: cover property (regRd && regAddr == 6'h11 && voltResultReadyFlag);
    overrun_c: cover property ($rose(voltOverrunFlag));
    attn_c: cover property (attentionReq);
endmodule
bind vmr_voltage_readout vmr_voltage_readout_asserts i_vmr_voltage_readout_asserts (.clk, .rstn,
    .regRd, .regAddr, .regRdata, .voltResultReadyFlag, .voltOverrunFlag, .attentionReq);

// File: testbench/test_vmr_voltage_readout.sv
module test_vmr_voltage_readout;
    timeunit 1ns;
    timeprecision 1ns;
    import vmr_pkg::*;
    // ========
    // Signals
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic lowPowerFlag = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [15:0] regWdata = 16'h0000;
    logic [15:0] regRdata;
    logic [15:0] rdVal;
    logic [9:0] adcRaw;
    logic adcUnder, voltResultReadyFlag, voltOverrunFlag, attentionReq;
    logic [2:0] convSensor;
    int miscompares = 0;
    int checked = 0;
    int attnCount = 0;
    int waited = 0;
    // Interval unit in clocks for this run
    localparam int unsigned BASE_CYC = 100;
    // Expected scan with sensors 0,1,3,4 on
    logic [2:0] scanIdx [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [8:0] scanCode [4] = '{9'h000, 9'h181, 9'h183, 9'h1FF};
    // Short counts keep the run brief
    vmr_voltage_readout #(.VOLT_CONV_CYCLES(6), .TEMP_CONV_CYCLES(4),
        .BASE_INTERVAL_CYCLES(BASE_CYC))
    i_vmr_voltage_readout (.clk, .rstn, .regWr, .regRd, .regAddr, .regWdata, .regRdata,
        .lowPowerFlag, .adcRaw, .adcUnder, .voltResultReadyFlag, .voltOverrunFlag,
        .attentionReq, .convSensor);
    vmr_adc_model i_vmr_adc_model (.convSensor, .adcRaw, .adcUnder);
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
        if (attentionReq === 1'b1) attnCount++;
    // ========
    // Bus tasks, driven on the falling edge
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        regWr = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge clk);
        regWr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge clk);
        regRd = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRd = 1'b0;
        rdVal = regRdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for a stored result
    task automatic wait_rdy(input int lim);
        int n;
        n = 0;
        while (voltResultReadyFlag !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        waited = n;
        chk({15'h0000, voltResultReadyFlag}, 16'h0001);
    endtask
    task automatic test_done();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog, well beyond the roughly one thousand cycles needed
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
    // ========
    // Sequence
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        rd(6'h12);
        chk(rdVal, 16'h001F);
        rd(6'h20);
        chk(rdVal, 16'h0002);
        rd(6'h3F);
        chk(rdVal, 16'h0000);
        wr(6'h12, 16'hFFFF);
        rd(6'h12);
        chk(rdVal, 16'h07FF);
        wr(6'h20, 16'hFFFF);
        rd(6'h20);
        chk(rdVal, 16'h0003);
        // Settle, clear, then continuous scan with attention on
        wr(6'h12, 16'h0000);
        repeat (100) @(negedge clk);
        rd(6'h11);
        wr(6'h20, 16'h0000);
        attnCount = 0;
        wr(6'h12, 16'h06E0);
        for (int i = 0; i < 8; i++)
        begin
            wait_rdy(300);
            rd(6'h11);
            chk(rdVal, {scanCode[i % 4], 2'b00, scanIdx[i % 4], 2'b00});
        end
        chk(attnCount[15:0], 16'h0008);
        // Unread results pile up
        repeat (60) @(negedge clk);
        chk({15'h0000, voltOverrunFlag}, 16'h0001);
        rd(6'h11);
        // Latest store, sensor 1, has overwritten the unread ones
        chk(rdVal, {9'h181, 2'b00, 3'h1, 2'b00});
        chk({14'h0000, voltOverrunFlag, voltResultReadyFlag}, 16'h0000);
        // Attention enable off
        wr(6'h12, 16'h06C0);
        attnCount = 0;
        rd(6'h11);
        wait_rdy(300);
        // Let several stores pass so a missing gate would show
        repeat (40) @(negedge clk);
        chk(attnCount[15:0], 16'h0000);
        // No sensors: nothing stored
        wr(6'h12, 16'h0000);
        repeat (20) @(negedge clk);
        rd(6'h11);
        repeat (300) @(negedge clk);
        chk({15'h0000, voltResultReadyFlag}, 16'h0000);
        // Timed select in low power
        lowPowerFlag = 1'b1;
        wr(6'h20, 16'h0001);
        wr(6'h12, 16'h0040);
        wait_rdy(1000);
        rd(6'h11);
        chk(rdVal, 16'h0000);
        // Gap between stores is four units; read latency takes two cycles off
        wait_rdy(1000);
        chk(waited[15:0], 16'(4 * BASE_CYC - 2));
        // Mid-run reset restores the written registers
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        chk({14'h0000, voltOverrunFlag, voltResultReadyFlag}, 16'h0000);
        rd(6'h12);
        chk(rdVal, 16'h001F);
        rd(6'h20);
        chk(rdVal, 16'h0002);
        test_done();
    end
endmodule
